// >>> rtl/lpdpc_consts.svh
// Purpose: Timing and encoding constants for the precharge timing block
// Assumes: Device clock I_MCLK at 250 MHz; link clock counted in link cycles
// Notes: Counts are in link clock cycles unless named _CYC
`ifndef LPDPC_CONSTS_SVH
`define LPDPC_CONSTS_SVH
`define LPDPC_BANKS 8
`define LPDPC_BL 5'd8
`define LPDPC_WL 5'd4
`define LPDPC_RTP_CK 5'd2
`define LPDPC_WR_CK 5'd4
`define LPDPC_RPPB_CK 5'd4
`define LPDPC_RPAB_CK 5'd5
`define LPDPC_OP_PRE 4'hB
`define LPDPC_OP_RD_MASK 3'h5
`define LPDPC_OP_RD 3'h5
`define LPDPC_OP_WR 3'h1
`endif

// >>> rtl/lpdpc_pkg.sv
// Purpose: Types for the precharge timing block
// Assumes: Eight banks
// Notes: Command decoded from one rising link edge
package lpdpc_pkg;
  // Command as sampled on the bus
  typedef struct packed {
    logic cs_n;
    logic [9:0] ca;
  } lpdpc_cmd_t;
  // Per-bank state
  typedef enum logic [2:0] {
    LPDPC_OPEN = 3'b001,
    LPDPC_WAIT = 3'b010,
    LPDPC_PRE = 3'b100
  } lpdpc_state_t;
endpackage

// >>> rtl/lpdpc_top.sv
// Purpose: Auto-precharge and precharge tracking per bank of an LPDDR2 die
// Assumes: Controller keeps all spacing limits (listed below for reference)
// Notes: Link clock sampled by I_MCLK, commands taken on its rising edge
// Operation
// - Read-to-precharge starts BL/2-1 or BL/2-2
// - Auto close flag selects automatic precharge
// - Two-prefetch read auto precharge start time
// - Four-prefetch read auto precharge: later of BL/2 and BL/2-2+RU(tRTP)
// - Write auto precharge after write recovery
// - Precharge period from latest precharge command
// - Precharge encoding on rising edge
// - All bank flag selects one or eight
`timescale 1ns/1ps
`include "lpdpc_consts.svh"
module lpdpc_top
  import lpdpc_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  // Link pins
  input wire logic I_CK,
  input wire lpdpc_pkg::lpdpc_cmd_t I_CMD,
  // Variant select: high for four prefetch variant
  input wire logic I_FOUR_PREFETCH,
  // Status
  output logic [7:0] O_BANK_OPEN,
  output logic [7:0] O_BANK_PRECHARGING,
  output logic O_AUTO_CLOSE_START
);
  import lpdpc_pkg::*;

  logic ck_s1_reg, ck_s2_reg, ck_s3_reg; // Link clock synchroniser
  lpdpc_cmd_t cmd_s1_reg, cmd_s2_reg; // Command synchroniser
  logic rise; // Rising link edge seen
  logic is_pre, is_rd, is_wr; // Decoded commands
  logic [2:0] bank; // Addressed bank
  logic all_bank_flag; // Precharge-all select
  logic auto_close_flag; // Auto precharge request
  logic four_s1_reg; // First stage of variant pin sampling
  logic four_pf_reg; // Variant after two flops
  logic [4:0] rd_delay, wr_delay; // Auto precharge start delays
  logic [7:0] start_vec; // Per-bank auto precharge start this edge

  // Two-flop sampling of link pins
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      ck_s1_reg <= 1'b0;
      ck_s2_reg <= 1'b0;
      ck_s3_reg <= 1'b0;
      cmd_s1_reg <= '1;
      cmd_s2_reg <= '1;
    end else begin
      ck_s1_reg <= I_CK;
      ck_s2_reg <= ck_s1_reg;
      ck_s3_reg <= ck_s2_reg;
      cmd_s1_reg <= I_CMD;
      cmd_s2_reg <= cmd_s1_reg;
    end
  end

  // Two-flop sampling of the variant pin
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      four_s1_reg <= 1'b0;
      four_pf_reg <= 1'b0;
    end else begin
      four_s1_reg <= I_FOUR_PREFETCH;
      four_pf_reg <= four_s1_reg;
    end
  end

  // Decode on the rising link edge
  always_comb begin
    rise = ck_s2_reg & ~ck_s3_reg;
    is_pre = rise & ~cmd_s2_reg.cs_n & (cmd_s2_reg.ca[3:0] == `LPDPC_OP_PRE);
    is_rd = rise & ~cmd_s2_reg.cs_n & (cmd_s2_reg.ca[2:0] == `LPDPC_OP_RD);
    is_wr = rise & ~cmd_s2_reg.cs_n & (cmd_s2_reg.ca[2:0] == `LPDPC_OP_WR);
    bank = cmd_s2_reg.ca[9:7];
    all_bank_flag = cmd_s2_reg.ca[4];
    auto_close_flag = cmd_s2_reg.ca[0] & cmd_s2_reg.ca[3]; // flag field of the command word
  end

  // Start delays in link cycles
  always_comb begin
    if (four_pf_reg) begin
      // Later of BL/2 and BL/2-2+RU(tRTP)
      rd_delay = ((`LPDPC_BL >> 1) > ((`LPDPC_BL >> 1) - 5'd2 + `LPDPC_RTP_CK)) ?
                 (`LPDPC_BL >> 1) : ((`LPDPC_BL >> 1) - 5'd2 + `LPDPC_RTP_CK);
    end else begin
      rd_delay = (`LPDPC_BL >> 1) - 5'd1 + `LPDPC_RTP_CK;
    end
    wr_delay = `LPDPC_WL + (`LPDPC_BL >> 1) + 5'd1 + `LPDPC_WR_CK;
  end

  // Per-bank state and timers
  genvar g;
  generate
    for (g = 0; g < `LPDPC_BANKS; g++) begin : g_bank
      lpdpc_state_t st_reg; // Bank state
      logic [4:0] cnt_reg; // Link cycles left
      logic hit; // Command addresses this bank
      assign hit = (bank == 3'(g));
      assign start_vec[g] = (st_reg == LPDPC_WAIT) & rise & (cnt_reg == 5'd1);
      always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
          st_reg <= LPDPC_PRE;
          cnt_reg <= 5'd0;
        end else if (is_pre && (all_bank_flag || hit)) begin
          // Latest precharge restarts the period
          st_reg <= LPDPC_PRE;
          cnt_reg <= all_bank_flag ? `LPDPC_RPAB_CK : `LPDPC_RPPB_CK;
        end else if ((is_rd || is_wr) && hit && auto_close_flag) begin
          st_reg <= LPDPC_WAIT;
          cnt_reg <= is_rd ? rd_delay : wr_delay;
        end else if ((is_rd || is_wr) && hit) begin
          st_reg <= LPDPC_OPEN; // bank marked open
        end else if (rise) begin
          unique case (st_reg)
            LPDPC_OPEN: begin
              cnt_reg <= cnt_reg;
            end
            LPDPC_WAIT: begin
              // Internal precharge begins when the count ends
              if (cnt_reg == 5'd1) begin
                st_reg <= LPDPC_PRE;
                cnt_reg <= `LPDPC_RPPB_CK;
              end else begin
                cnt_reg <= cnt_reg - 5'd1;
              end
            end
            LPDPC_PRE: begin
              if (cnt_reg != 5'd0) begin
                cnt_reg <= cnt_reg - 5'd1;
              end
            end
            default: begin
              st_reg <= LPDPC_PRE;
            end
          endcase
        end
      end
      // Outputs from flops
      always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
          O_BANK_OPEN[g] <= 1'b0;
          O_BANK_PRECHARGING[g] <= 1'b0;
        end else begin
          O_BANK_OPEN[g] <= (st_reg != LPDPC_PRE);
          O_BANK_PRECHARGING[g] <= (st_reg == LPDPC_PRE) && (cnt_reg != 5'd0);
        end
      end
    end
  endgenerate

  // Pulse when any auto precharge starts
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_AUTO_CLOSE_START <= 1'b0;
    end else begin
      O_AUTO_CLOSE_START <= |start_vec;
    end
  end

  // Bank of the command decoded one cycle earlier, used by the checks below
  logic [2:0] bank_hold_reg;
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      bank_hold_reg <= 3'h0;
    end else begin
      bank_hold_reg <= bank;
    end
  end

  // Assertions
  property p_pre_closes;
    @(posedge I_MCLK) disable iff (I_RST)
    (is_pre && all_bank_flag) |=> ##1 (O_BANK_OPEN == 8'h00);
  endproperty
  a_pre_closes: assert property (p_pre_closes) else $error("Precharge all left a bank open");

  property p_preall_busy;
    @(posedge I_MCLK) disable iff (I_RST)
    (is_pre && all_bank_flag) |=> ##1 (O_BANK_PRECHARGING == 8'hFF);
  endproperty
  a_preall_busy: assert property (p_preall_busy) else $error("Precharge all did not start every period");

  property p_start_pulse;
    @(posedge I_MCLK) disable iff (I_RST)
    (|start_vec) |=> O_AUTO_CLOSE_START;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("Auto close start not flagged");

  property p_pre_busy;
    @(posedge I_MCLK) disable iff (I_RST)
    (is_pre && !all_bank_flag) |=> ##1 O_BANK_PRECHARGING[bank_hold_reg];
  endproperty
  a_pre_busy: assert property (p_pre_busy) else $error("Single bank precharge not tracked");

  property p_open_rw;
    @(posedge I_MCLK) disable iff (I_RST)
    ((is_rd || is_wr) && !auto_close_flag && !is_pre) |=> ##1 O_BANK_OPEN[bank_hold_reg];
  endproperty
  a_open_rw: assert property (p_open_rw) else $error("Plain access closed the bank");

  // Bank still open two cycles after an access with auto close
  property p_auto_wait;
    @(posedge I_MCLK) disable iff (I_RST)
    ((is_rd || is_wr) && auto_close_flag && !is_pre) |=> ##1 O_BANK_OPEN[bank_hold_reg];
  endproperty
  a_auto_wait: assert property (p_auto_wait) else $error("Auto close access closed the bank at once");

  c_auto: cover property (@(posedge I_MCLK) disable iff (I_RST) O_AUTO_CLOSE_START);
  c_preall: cover property (@(posedge I_MCLK) disable iff (I_RST) is_pre && all_bank_flag);
  c_rd_auto: cover property (@(posedge I_MCLK) disable iff (I_RST) is_rd && auto_close_flag);
endmodule

// >>> verification/lpdpc_ctrl_model.sv
// Purpose: Controller model driving the link clock and command bus
// Assumes: Link period 80 ns, made as 20 system cycles
// Notes: Deselected bus shows the inverse of the last word
`timescale 1ns/1ps
module lpdpc_ctrl_model
  import lpdpc_pkg::*;
(
  // System clock
  input wire logic i_mclk,
  // Link pins
  output logic o_ck,
  output lpdpc_pkg::lpdpc_cmd_t o_cmd
);
  logic [4:0] phase_reg; // Position within link period
  int rises; // Count of link rising edges

  initial begin
    o_ck = 1'b0;
    o_cmd = '{cs_n: 1'b1, ca: 10'h000};
    phase_reg = 5'h00;
    rises = 0;
  end

  // Free-running link clock
  always @(posedge i_mclk) begin
    phase_reg <= (phase_reg == 5'h13) ? 5'h00 : phase_reg + 5'h01;
    if (phase_reg == 5'h09) begin
      o_ck <= 1'b1;
      rises <= rises + 1;
    end
    if (phase_reg == 5'h13) o_ck <= 1'b0;
  end

  // One command held across one rising edge, then deselect
  task automatic issue(input logic [9:0] ca, output int at);
    do @(posedge i_mclk); while (phase_reg != 5'h13);
    // Whole bursts only: no burst cut is ever sent
    o_cmd <= '{cs_n: 1'b0, ca: ca};
    at = rises + 1;
    do @(posedge i_mclk); while (phase_reg != 5'h13);
    o_cmd <= '{cs_n: 1'b1, ca: ~ca};
  endtask
endmodule

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the precharge timing block
// Assumes: Header timing values; link edges counted by the model
// Notes: Checks are made 8 system cycles after a link rising edge, 10 for the one right after an issue, 3 after reset release for the reset checks
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); end end
module tb_top;
  import lpdpc_pkg::*;
  logic mclk = 1'b0; // System clock
  logic rst = 1'b1; // Reset, active high
  logic four_q = 1'b0; // Variant select
  logic ck; // Link clock
  lpdpc_cmd_t cmd; // Command word
  logic [7:0] open_w, pre_w; // Bank status
  logic start_w; // Auto close pulse
  int err_total = 0;
  int n_compared = 0;
  int p_cnt = 0;
  int p_at = 0;

  always #2 mclk = ~mclk;

  lpdpc_ctrl_model m (.i_mclk(mclk), .o_ck(ck), .o_cmd(cmd));
  lpdpc_top dut (.I_MCLK(mclk), .I_RST(rst), .I_CK(ck), .I_CMD(cmd), .I_FOUR_PREFETCH(four_q),
    .O_BANK_OPEN(open_w), .O_BANK_PRECHARGING(pre_w), .O_AUTO_CLOSE_START(start_w));

  // Record auto close pulses against the link edge count
  always @(posedge mclk) if (start_w === 1'b1) begin
    p_cnt++;
    p_at = m.rises;
  end

  task automatic rise_wait(input int n);
    repeat (n) do @(posedge mclk); while (m.phase_reg != 5'h09);
    repeat (8) @(posedge mclk);
  endtask

  // Precharge one bank or all, check the period ends exactly rp link edges on
  task automatic t_pre(input logic all_sel, input logic [2:0] bk, input int rp, input logic [7:0] exp);
    int at;
    m.issue({bk, 2'b00, all_sel, 4'hB}, at);
    rise_wait(1);
    `CHK(pre_w, exp)
    rise_wait(rp - 2);
    `CHK(pre_w, exp)
    rise_wait(1);
    `CHK(pre_w, 8'h00)
  endtask

  // Read or write, with or without auto close; k of 0 means no pulse
  task automatic t_auto(input logic four, input logic [9:0] ca, input int k);
    int at, n0;
    four_q <= four;
    rise_wait(2);
    n0 = p_cnt;
    m.issue(ca, at);
    `CHK(open_w[0], 1'b1)
    rise_wait(16);
    `CHK(p_cnt - n0, (k > 0) ? 1 : 0)
    if (k > 0) `CHK(p_at - at, k)
    `CHK(open_w[0], k == 0)
  endtask

  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    complete_run;
  end

  initial begin
    int at;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK(pre_w, 8'h00)
    `CHK(open_w, 8'h00)
    for (int b = 0; b < 8; b++) t_pre(1'b0, b[2:0], 4, 8'h01 << b);
    // Bank 3 precharged two link cycles before all banks
    m.issue(10'h18B, at);
    t_pre(1'b1, 3'h0, 5, 8'hFF);
    `CHK(open_w, 8'h00)
    t_auto(1'b1, 10'h00D, 4);
    t_auto(1'b0, 10'h00D, 5);
    t_auto(1'b0, 10'h005, 0);
    t_auto(1'b1, 10'h009, 13);
    t_auto(1'b0, 10'h001, 0);
    complete_run;
  end
endmodule
